// file: core/fbos_bridge.sv
`timescale 1ns/1ps
// Notes on behaviour
// R1: Forward: A active, B C off, D modulates
// R2: Reverse: C active, A D off, B modulates
// R3: Dead band on every direction change
// R4: Steering settings ignored in full-bridge modes
// R5: Toggling mode bit 0 reverses while running
// R6: New leg held inactive until delay elapses
module fbos_bridge
  import fbos_pkg::*;
#(
  parameter int DB_W = FBOS_DB_W
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Control
  input wire logic enable,
  input wire logic [FBOS_MODE_W-1:0] mode,
  input wire logic [DB_W-1:0] dead_band_count,
  input wire logic [3:0] steer_en,
  input wire logic [3:0] out_pol,
  // Modulating input, asynchronous pin
  input wire logic mod_in,
  // Bridge drive
  output logic bridge_out_a,
  output logic bridge_out_b,
  output logic bridge_out_c,
  output logic bridge_out_d,
  output logic dead_band_busy
);
  // Counter width limits; anything wider is no sensible dead band
  if (DB_W < 1 || DB_W > 16) begin : g_bad_db_w
    $error("fbos_bridge: DB_W out of range");
  end

  // ----------------------------------------
  // Input conditioning
  // ----------------------------------------
  logic mod_s;
  fbos_sync u_sync (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .din(mod_in),
    .dout(mod_s)
  );

  function automatic fbos_dir_t decode_dir(input logic en, input logic [2:0] m);
    if (!en) begin
      return FBOS_DIR_NONE;
    end
    case (m)
      FBOS_MODE_FWD: return FBOS_DIR_FWD;
      FBOS_MODE_REV: return FBOS_DIR_REV;
      default: return FBOS_DIR_NONE;
    endcase
  endfunction

  // ----------------------------------------
  // Direction tracking and dead band
  // ----------------------------------------
  fbos_dir_t dir_now;
  fbos_dir_t dir_r;
  logic [DB_W-1:0] db_cnt_r;
  logic [DB_W-1:0] db_cnt_nxt;
  logic dir_flip;

  // Only mode bit 0 differs between the two bridge modes, so a flip is seen
  // here without the generator ever passing through disable
  assign dir_now = decode_dir(enable, mode); // R5
  assign dir_flip = (dir_r == FBOS_DIR_FWD && dir_now == FBOS_DIR_REV) ||
                    (dir_r == FBOS_DIR_REV && dir_now == FBOS_DIR_FWD); // R3

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      dir_r <= FBOS_DIR_NONE;
    end else begin
      dir_r <= dir_now;
    end
  end

  always_comb begin
    db_cnt_nxt = db_cnt_r;
    if (dir_now == FBOS_DIR_NONE) begin
      db_cnt_nxt = '0;
    end else if (dir_flip) begin
      // Flip edge is the first held cycle, so load one less
      db_cnt_nxt = (dead_band_count != '0) ? dead_band_count - 1'b1 : '0; // R3
    end else if (db_cnt_r != '0) begin
      db_cnt_nxt = db_cnt_r - 1'b1; // R6
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      db_cnt_r <= '0;
    end else begin
      db_cnt_r <= db_cnt_nxt;
    end
  end

  // ----------------------------------------
  // Output steering
  // ----------------------------------------
  logic [3:0] act;
  logic hold;
  // Counter not loaded yet on the flip edge itself
  assign hold = dir_flip ? (dead_band_count != '0) : (db_cnt_r != '0);

  // Active-level vector a,b,c,d before polarity; steer_en deliberately
  // unused in bridge modes; other modes leave outputs inactive here
  always_comb begin
    act = FBOS_STEER_NONE;
    case (dir_now)
      FBOS_DIR_FWD: act = {1'b1, 1'b0, 1'b0, mod_s}; // R1 R4
      FBOS_DIR_REV: act = {1'b0, mod_s, 1'b1, 1'b0}; // R2 R4
      default: act = FBOS_STEER_NONE;
    endcase
    // Whole new leg kept off until the delay runs out
    if (hold) begin
      act = FBOS_STEER_NONE; // R6
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      {bridge_out_a, bridge_out_b, bridge_out_c, bridge_out_d} <= FBOS_OUT_RESET;
      dead_band_busy <= 1'b0;
    end else begin
      {bridge_out_a, bridge_out_b, bridge_out_c, bridge_out_d} <= act ^ out_pol;
      dead_band_busy <= hold;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // Outputs show what was decided one edge earlier, so polarity and
  // modulation are compared with their past values
  sequence s_flip;
    dir_flip && dead_band_count > FBOS_DB_ONE;
  endsequence

  sequence s_flip_one;
    dir_flip && dead_band_count == FBOS_DB_ONE;
  endsequence

  sequence s_flip_none;
    dir_flip && dead_band_count == '0;
  endsequence

  // A second flip at once may legally restart the hold
  sequence s_one_busy;
    dead_band_busy ##1 (!dead_band_busy || $past(dir_flip));
  endsequence

  sequence s_enter;
    dir_r == FBOS_DIR_NONE && dir_now != FBOS_DIR_NONE;
  endsequence

  // Leg levels in each direction
  a_fwd_levels: assert property (@(posedge ref_clk) disable iff (!rst_b) // R1
    (dir_now == FBOS_DIR_FWD && !hold) |=> (bridge_out_a == !$past(out_pol[3])) &&
    (bridge_out_b == $past(out_pol[2])) && (bridge_out_c == $past(out_pol[1])))
    else $error("forward levels wrong");
  a_fwd_mod: assert property (@(posedge ref_clk) disable iff (!rst_b) // R1
    (dir_now == FBOS_DIR_FWD && !hold) |=>
    (bridge_out_d == ($past(mod_s) ^ $past(out_pol[0]))))
    else $error("forward D not modulated");
  a_rev_levels: assert property (@(posedge ref_clk) disable iff (!rst_b) // R2
    (dir_now == FBOS_DIR_REV && !hold) |=> (bridge_out_c == !$past(out_pol[1])) &&
    (bridge_out_a == $past(out_pol[3])) && (bridge_out_d == $past(out_pol[0])))
    else $error("reverse levels wrong");
  a_rev_mod: assert property (@(posedge ref_clk) disable iff (!rst_b) // R2
    (dir_now == FBOS_DIR_REV && !hold) |=>
    (bridge_out_b == ($past(mod_s) ^ $past(out_pol[2]))))
    else $error("reverse B not modulated");

  // Dead band sizing on a change of direction
  a_flip_busy: assert property (@(posedge ref_clk) disable iff (!rst_b) // R3
    s_flip |=> dead_band_busy [*2])
    else $error("dead band not applied");
  a_flip_any_busy: assert property (@(posedge ref_clk) disable iff (!rst_b) // R3
    (dir_flip && dead_band_count != '0) |=> dead_band_busy)
    else $error("dead band missing on flip");
  a_zero_no_db: assert property (@(posedge ref_clk) disable iff (!rst_b) // R3
    s_flip_none |=> !dead_band_busy)
    else $error("dead band with zero count");
  // Switching on from off is no reversal
  a_enter_no_db: assert property (@(posedge ref_clk) disable iff (!rst_b) // R3
    s_enter |=> !dead_band_busy)
    else $error("dead band on switch-on");

  // Steering bits and the live toggle
  a_steer_ignored: assert property (@(posedge ref_clk) disable iff (!rst_b) // R4
    (dir_now != FBOS_DIR_NONE && !hold && $stable(hold) && $changed(steer_en) &&
     $stable(mod_s) && $stable(dir_now) && $stable(out_pol)) |=>
    $stable({bridge_out_a, bridge_out_b, bridge_out_c, bridge_out_d}))
    else $error("steering affected bridge");
  a_toggle_flip: assert property (@(posedge ref_clk) disable iff (!rst_b) // R5
    (enable && $stable(enable) && mode[2:1] == FBOS_MODE_FWD[2:1] &&
     $stable(mode[2:1]) && $changed(mode[0]) && dir_r != FBOS_DIR_NONE) |-> dir_flip)
    else $error("bit 0 toggle missed");

  // Held leg and its release
  a_hold_off: assert property (@(posedge ref_clk) disable iff (!rst_b) // R6
    hold |=> ({bridge_out_a, bridge_out_b, bridge_out_c, bridge_out_d} == $past(out_pol)))
    else $error("leg driven in dead band");
  a_busy_legs_off: assert property (@(posedge ref_clk) disable iff (!rst_b) // R6
    dead_band_busy |-> ({bridge_out_a, bridge_out_b, bridge_out_c, bridge_out_d} ==
    $past(out_pol)))
    else $error("busy shown with a leg on");
  a_db_one_cycle: assert property (@(posedge ref_clk) disable iff (!rst_b) // R6
    s_flip_one |=> s_one_busy)
    else $error("one-cycle dead band wrong");
  // Counter must not stall while a leg waits
  a_db_count_down: assert property (@(posedge ref_clk) disable iff (!rst_b) // R6
    (db_cnt_r != '0 && !dir_flip && dir_now != FBOS_DIR_NONE) |=>
    (db_cnt_r == $past(db_cnt_r) - 1'b1))
    else $error("dead band count stalled");
  // Count one marks the last held edge
  a_hold_ends: assert property (@(posedge ref_clk) disable iff (!rst_b) // R6
    (db_cnt_r == FBOS_DB_ONE && !dir_flip && dir_now != FBOS_DIR_NONE) |=>
    ((db_cnt_r == '0) && (!hold || dir_flip)))
    else $error("dead band overran");
endmodule // fbos_bridge

// file: core/fbos_pkg.sv
package fbos_pkg;
  // Mode field encodings
  localparam logic [2:0] FBOS_MODE_FWD = 3'h2;
  localparam logic [2:0] FBOS_MODE_REV = 3'h3;
  localparam int FBOS_MODE_W = 3;
  // Dead-band count width and default
  localparam int FBOS_DB_W = 6;
  localparam logic [5:0] FBOS_DB_DEFAULT = 6'h02;
  localparam logic [5:0] FBOS_DB_ZERO = 6'h00;
  localparam logic [5:0] FBOS_DB_ONE = 6'h01;
  // Output reset value and inactive steering vector
  localparam logic [3:0] FBOS_OUT_RESET = 4'h0;
  localparam logic [3:0] FBOS_STEER_NONE = 4'h0;
  typedef enum logic [1:0] {FBOS_DIR_NONE, FBOS_DIR_FWD, FBOS_DIR_REV} fbos_dir_t;
endpackage

// file: core/fbos_sync.sv
`timescale 1ns/1ps
module fbos_sync (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Raw and cleaned level
  input wire logic din,
  output logic dout
);
  logic s1_r;
  logic s2_r;
  logic s3_r;

  // Three stages; change accepted when the last two agree
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      dout <= 1'b0;
    end else if (s2_r == s3_r) begin
      dout <= s3_r;
    end
  end
endmodule // fbos_sync

// file: bench/fbos_drive_stage.sv
`timescale 1ns/1ps
module fbos_drive_stage (
  // Gate drive and polarity
  input wire logic drv_a,
  input wire logic drv_b,
  input wire logic drv_c,
  input wire logic drv_d,
  input wire logic [3:0] pol,
  // A switch of each diagonal on at once
  output logic shoot_thru
);
  logic [3:0] on_w;
  assign on_w = {drv_a, drv_b, drv_c, drv_d} ^ pol;
  // A real stage shorts the supply here, so no slack is given
  assign shoot_thru = (on_w[3] | on_w[0]) & (on_w[2] | on_w[1]);
endmodule // fbos_drive_stage

// file: bench/tb_full_bridge_output_steering.sv
`timescale 1ns/1ps
module tb_full_bridge_output_steering;
  import fbos_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic enable = 1'b0;
  logic [2:0] mode = 3'h0;
  logic [5:0] db_cnt = 6'h00;
  logic [3:0] steer_en = 4'h0;
  logic [3:0] out_pol = 4'h0;
  logic [3:0] pol_q = 4'h0;
  logic mod_in = 1'b0;
  logic a, b, c, d, busy, shoot;
  int bad_count = 0;
  int total_checks = 0;
  int cyc = 0;

  always #5 ref_clk = ~ref_clk;
  // Outputs lag polarity by one edge; keep the stage in step
  always @(posedge ref_clk) pol_q <= out_pol;

  fbos_bridge i_dut (.ref_clk(ref_clk), .rst_b(rst_b), .enable(enable), .mode(mode),
    .dead_band_count(db_cnt), .steer_en(steer_en), .out_pol(out_pol), .mod_in(mod_in),
    .bridge_out_a(a), .bridge_out_b(b), .bridge_out_c(c), .bridge_out_d(d),
    .dead_band_busy(busy));

  fbos_drive_stage i_stage (.drv_a(a), .drv_b(b), .drv_c(c), .drv_d(d), .pol(pol_q),
    .shoot_thru(shoot));

  task automatic print_verdict;
    if (bad_count == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  always @(negedge ref_clk) begin
    cyc++;
    if (rst_b && shoot !== 1'b0) begin
      bad_count++;
      $display("Error at %0t: shoot %h expected %h", $time, shoot, 1'b0);
    end
    if (cyc > 2000) begin
      bad_count++;
      print_verdict();
    end
  end

  task automatic cyc_n(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  task automatic check(input logic [3:0] pat, input logic bz);
    logic [4:0] exp;
    exp = {pat ^ out_pol, bz};
    total_checks++;
    if ({a, b, c, d, busy} !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, {a, b, c, d, busy}, exp);
    end
  endtask

  task automatic t_enter;
    enable = 1'b1;
    steer_en = 4'hF;
    mode = FBOS_MODE_FWD;
    mod_in = 1'b1;
    cyc_n(8);
    check(4'b1001, 1'b0);
    // Steering moved while bridged must leave the legs alone
    steer_en = 4'h0;
    cyc_n(2);
    check(4'b1001, 1'b0);
    mod_in = 1'b0;
    cyc_n(8);
    check(4'b1000, 1'b0);
  endtask

  // Leaving bridge mode drops every leg to its inactive level
  task automatic t_off;
    enable = 1'b0;
    cyc_n(2);
    check(4'b0000, 1'b0);
  endtask

  // Flip direction with mod high, so a missing dead band shows
  task automatic t_flip(input logic [2:0] m, input logic [5:0] n, input logic [3:0] hi,
                        input logic [3:0] lo);
    db_cnt = n;
    mod_in = 1'b1;
    cyc_n(8);
    mode = m;
    cyc_n(1);
    repeat (int'(n)) begin
      check(4'b0000, 1'b1);
      cyc_n(1);
    end
    // Release due exactly n edges after the flip edge
    check(hi, 1'b0);
    mod_in = 1'b0;
    cyc_n(8);
    check(lo, 1'b0);
  endtask

  initial begin
    cyc_n(2);
    rst_b = 1'b1;
    cyc_n(1);
    t_enter();
    t_flip(FBOS_MODE_REV, 6'h03, 4'b0110, 4'b0010);
    t_flip(FBOS_MODE_FWD, 6'h01, 4'b1001, 4'b1000);
    out_pol = 4'h5;
    t_flip(FBOS_MODE_REV, 6'h00, 4'b0110, 4'b0010);
    t_off();
    print_verdict();
  end
endmodule // tb_full_bridge_output_steering
